// ==== design/ppm_defines.svh ====
// Register offsets, field positions, reset values and counts of the port.
// Assumes inclusion by bare name from the port module, the checker and the bench.
`ifndef PPM_DEFINES_SVH
`define PPM_DEFINES_SVH
`define PPM_AW 4
`define PPM_A_MODE 4'h0
`define PPM_A_ADDR 4'h1
`define PPM_A_PEN 4'h2
`define PPM_A_STAT 4'h3
`define PPM_A_PAD 4'h4
`define PPM_A_CTRL 4'h5
`define PPM_A_OUT1 4'h6
`define PPM_A_OUT2 4'h7
`define PPM_A_IN1 4'h8
`define PPM_A_IN2 4'h9
`define PPM_A_DATA 4'hA
`define PPM_F_BUSY 15
`define PPM_F_IRQ 14:13
`define PPM_F_INC 12:11
`define PPM_F_WIDE 10
`define PPM_F_MODE 9:8
`define PPM_F_SETUP 7:6
`define PPM_F_STRB 5:2
`define PPM_F_HOLD 1:0
`define PPM_F_ON 15
`define PPM_F_INBUF_OVERFLOW 14
`define PPM_F_OUTBUF_UNDERFLOW 6
`define PPM_F_ADR 13:0
`define PPM_F_CS1 14
`define PPM_F_CS2 15
`define PPM_MODE_RST 15'h0000
`define PPM_WORD_RST 16'h0000
`define PPM_EMPTY_RST 4'hF
`define PPM_GAP_CYC 1
`endif

// ==== design/ppm_pkg.sv ====
// Types shared by the parallel port: port modes, policies and states.
// Assumes ppm_defines.svh is on the include path.
package ppm_pkg;
  typedef enum logic [1:0] {
    PPM_LEGACY = 2'h0, PPM_ENH = 2'h1, PPM_MST2 = 2'h2, PPM_MST1 = 2'h3
  } ppm_mode_e;
  typedef enum logic [1:0] {
    PPM_IRQ_NONE = 2'h0, PPM_IRQ_CYC = 2'h1, PPM_IRQ_STALL = 2'h2, PPM_IRQ_BUF3 = 2'h3
  } ppm_irq_e;
  typedef enum logic [1:0] {
    PPM_INC_NONE = 2'h0, PPM_INC_UP = 2'h1, PPM_INC_DOWN = 2'h2, PPM_INC_PTR = 2'h3
  } ppm_inc_e;
  typedef enum logic [4:0] {
    PPM_IDLE = 5'h01, PPM_SETUP = 5'h02, PPM_STRB = 5'h04, PPM_HOLD = 5'h08,
    PPM_GAP = 5'h10
  } ppm_state_e;
endpackage : ppm_pkg

// ==== design/ppm_port.sv ====
// Parallel port with master transfers and a four byte slave buffer.
// Assumes one 100 MHz clock, one cycle per instruction cycle, and host pins
// that are asynchronous and therefore synchronised here.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "ppm_defines.svh"

// Functional notes
// - Read-only busy flag during master transfers.
// - Policy 11 interrupts on buffer three.
// - Policy 10 stalls; policy 00 does nothing.
// - Policy 01 interrupts after every cycle.
// - Auto-change decrements, increments or keeps address.
// - Code 11 advances legacy slave buffer pointers.
// - Wide data gives two byte transfers.
// - Modes 11 and 10 select master strobes.
// - Modes 01 and 00 select slave ports.
// - Setup phase lasts field plus one cycles.
// - Strobe lasts field plus one cycles.
// - Hold phase lasts field plus one cycles.
// - Zero strobe wait skips setup and hold.
// - One idle cycle between consecutive transfers.
// - Address register holds address and selects.
// - Pin enable bits hand pins to port.
// - Per-buffer full flags and summary full.
// - Sticky overflow on write to full buffer.
// - Per-buffer empty flags reset high, summary.
// - Sticky underflow on read of empty buffer.
// - Host address lines pick the byte buffer in mode 01.
// - Fields reset zero, empty flags reset one.
// - Module off means no off-chip accesses.
module ppm_port (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [`PPM_AW-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // Data pins
  input wire logic [7:0] i_data_lines,
  output logic [7:0] o_data_lines,
  output logic o_data_lines_oe,
  // Master pins
  output logic [15:0] o_address_lines,
  output logic [15:0] o_address_lines_oe,
  output logic o_read_strobe,
  output logic o_write_strobe,
  output logic o_chip_select_one,
  output logic o_chip_select_two,
  output logic o_byte_enable,
  // Host pins in slave modes
  input wire logic i_host_read,
  input wire logic i_host_write,
  input wire logic i_host_select,
  input wire logic [1:0] i_host_addr,
  // Processor side
  output logic o_irq,
  output logic o_stall,
  output logic o_pad_ttl
);
  import ppm_pkg::*;

  logic [14:0] mode_q;
  logic [15:0] addr_q;
  logic [15:0] pen_q;
  logic [1:0] pad_q;
  logic on_q;
  logic [7:0] ob_q [4];
  logic [7:0] ib_q [4];
  logic [3:0] full_q;
  logic [3:0] empty_q;
  logic ovf_q;
  logic unf_q;
  logic [15:0] mdata_q;
  ppm_state_e state_q;
  logic [3:0] cnt_q;
  logic byte_q;
  logic dir_q;
  logic [1:0] wptr_q;
  logic [1:0] rptr_q;
  logic [15:0] rdata_q;
  logic [7:0] dout_q;
  logic irq_q;
  logic [12:0] sync1_q;
  logic [12:0] sync2_q;
  logic [12:0] sync3_q;

  // Register decode.
  wire wr_mode = i_wr && (i_addr == `PPM_A_MODE);
  wire wr_addr = i_wr && (i_addr == `PPM_A_ADDR);
  wire wr_pen = i_wr && (i_addr == `PPM_A_PEN);
  wire wr_stat = i_wr && (i_addr == `PPM_A_STAT);
  wire wr_pad = i_wr && (i_addr == `PPM_A_PAD);
  wire wr_ctrl = i_wr && (i_addr == `PPM_A_CTRL);
  wire wr_out1 = i_wr && (i_addr == `PPM_A_OUT1);
  wire wr_out2 = i_wr && (i_addr == `PPM_A_OUT2);
  wire wr_data = i_wr && (i_addr == `PPM_A_DATA);
  wire rd_in1 = i_rd && (i_addr == `PPM_A_IN1);
  wire rd_in2 = i_rd && (i_addr == `PPM_A_IN2);
  wire rd_data = i_rd && (i_addr == `PPM_A_DATA);

  // Mode fields.
  wire [1:0] f_irq = mode_q[`PPM_F_IRQ];
  wire [1:0] f_inc = mode_q[`PPM_F_INC];
  wire f_wide = mode_q[`PPM_F_WIDE];
  wire [1:0] f_mode = mode_q[`PPM_F_MODE];
  wire [1:0] f_setup = mode_q[`PPM_F_SETUP];
  wire [3:0] f_strb = mode_q[`PPM_F_STRB];
  wire [1:0] f_hold = mode_q[`PPM_F_HOLD];
  wire is_master = f_mode[1];
  wire is_legacy = (f_mode == PPM_LEGACY);
  wire is_enh = (f_mode == PPM_ENH);
  wire no_wait = (f_strb == 4'h0);

  wire busy = (state_q != PPM_IDLE);
  wire in_xfer = busy && (state_q != PPM_GAP);
  wire start = on_q && is_master && !busy && (wr_data || rd_data);
  wire first_ph = no_wait ? 1'b0 : 1'b1;
  wire ph_end = (cnt_q == 4'h0);
  wire last_byte = !f_wide || byte_q;
  wire done = (state_q == PPM_GAP) && last_byte;

  // Slave strobes: stage two gives the level, stage three its history.
  wire s_rd = sync2_q[0] && sync2_q[2];
  wire s_wr = sync2_q[1] && sync2_q[2];
  wire p_rd = sync3_q[0] && sync3_q[2];
  wire p_wr = sync3_q[1] && sync3_q[2];
  wire slave_on = on_q && !is_master;
  wire host_rd_ev = slave_on && p_rd && !s_rd;
  wire host_wr_ev = slave_on && p_wr && !s_wr;
  wire [7:0] host_byte = sync3_q[12:5];
  wire [1:0] host_a = sync2_q[4:3];
  // Legacy mode uses buffer zero unless the pointers are enabled.
  wire ptr_mode = is_legacy && (f_inc == PPM_INC_PTR);
  wire [1:0] widx = is_enh ? host_a : (ptr_mode ? wptr_q : 2'h0);
  wire [1:0] ridx = is_enh ? host_a : (ptr_mode ? rptr_q : 2'h0);
  wire wr_ovf = host_wr_ev && full_q[widx];
  wire rd_unf = host_rd_ev && empty_q[ridx];

  // Interrupt sources.
  wire cyc_end = done || host_rd_ev || host_wr_ev;
  wire buf3_rd = host_rd_ev && (ridx == 2'h3);
  wire buf3_wr = host_wr_ev && (widx == 2'h3);
  wire irq_cyc = (f_irq == PPM_IRQ_CYC) && cyc_end;
  wire irq_b3 = (f_irq == PPM_IRQ_BUF3) && !is_master && (buf3_rd || buf3_wr);

  // Address auto change of the low eleven bits.
  wire [10:0] a_lo = addr_q[10:0];
  wire [10:0] a_inc = a_lo + 11'h001;
  wire [10:0] a_dec = a_lo - 11'h001;
  wire [10:0] a_next = (f_inc == PPM_INC_UP) ? a_inc :
                       (f_inc == PPM_INC_DOWN) ? a_dec : a_lo;

  wire [15:0] stat_word = {&full_q, ovf_q, 2'h0, full_q,
                           &empty_q, unf_q, 2'h0, empty_q};
  wire [15:0] ctrl_word = {on_q, 15'h0000};
  wire [15:0] mode_word = {busy, mode_q};
  wire [15:0] rd_mux =
    (i_addr == `PPM_A_MODE) ? mode_word :
    (i_addr == `PPM_A_ADDR) ? addr_q :
    (i_addr == `PPM_A_PEN) ? pen_q :
    (i_addr == `PPM_A_STAT) ? stat_word :
    (i_addr == `PPM_A_PAD) ? {14'h0000, pad_q} :
    (i_addr == `PPM_A_CTRL) ? ctrl_word :
    (i_addr == `PPM_A_OUT1) ? {ob_q[1], ob_q[0]} :
    (i_addr == `PPM_A_OUT2) ? {ob_q[3], ob_q[2]} :
    (i_addr == `PPM_A_IN1) ? {ib_q[1], ib_q[0]} :
    (i_addr == `PPM_A_IN2) ? {ib_q[3], ib_q[2]} :
    (i_addr == `PPM_A_DATA) ? mdata_q : 16'h0000;

  // Host pins, data lines included, pass two flops before any use.
  always_ff @(posedge i_sys_clk) begin
    sync1_q <= {i_data_lines, i_host_addr, i_host_select, i_host_write, i_host_read};
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      mode_q <= `PPM_MODE_RST;
      pen_q <= `PPM_WORD_RST;
      pad_q <= 2'h0;
      on_q <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_q <= i_wdata[14:0];
      end
      if (wr_pen) begin
        pen_q <= i_wdata;
      end
      if (wr_pad) begin
        pad_q <= i_wdata[1:0];
      end
      if (wr_ctrl) begin
        on_q <= i_wdata[`PPM_F_ON];
      end
    end
  end

  // A completed cycle moves the address even over a software write.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      addr_q <= `PPM_WORD_RST;
    end else if (done) begin
      addr_q <= {addr_q[15:11], a_next};
    end else if (wr_addr) begin
      addr_q <= i_wdata;
    end
  end

  // Master transfer sequencer.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q <= PPM_IDLE;
      cnt_q <= 4'h0;
      byte_q <= 1'b0;
      dir_q <= 1'b0;
    end else begin
      case (state_q)
        PPM_IDLE: begin
          if (start) begin
            dir_q <= rd_data;
            byte_q <= 1'b0;
            state_q <= first_ph ? PPM_SETUP : PPM_STRB;
            cnt_q <= first_ph ? {2'h0, f_setup} : 4'h0;
          end
        end
        PPM_SETUP: begin
          if (ph_end) begin
            state_q <= PPM_STRB;
            cnt_q <= f_strb;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        PPM_STRB: begin
          if (ph_end) begin
            state_q <= no_wait ? PPM_GAP : PPM_HOLD;
            cnt_q <= {2'h0, f_hold};
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        PPM_HOLD: begin
          if (ph_end) begin
            state_q <= PPM_GAP;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        PPM_GAP: begin
          if (last_byte) begin
            state_q <= PPM_IDLE;
          end else begin
            byte_q <= 1'b1;
            state_q <= first_ph ? PPM_SETUP : PPM_STRB;
            cnt_q <= first_ph ? {2'h0, f_setup} : 4'h0;
          end
        end
        default: begin
          state_q <= PPM_IDLE;
        end
      endcase
    end
  end

  // Master data word: written by software, filled byte by byte on reads.
  wire cap = (state_q == PPM_STRB) && ph_end && dir_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      mdata_q <= `PPM_WORD_RST;
    end else if (cap && byte_q) begin
      mdata_q[15:8] <= sync2_q[12:5];
    end else if (cap) begin
      mdata_q[7:0] <= sync2_q[12:5];
    end else if (wr_data && !busy) begin
      mdata_q <= i_wdata;
    end
  end

  // Slave buffers and their flags; hardware setting wins over clearing.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      full_q <= 4'h0;
      empty_q <= `PPM_EMPTY_RST;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      wptr_q <= 2'h0;
      rptr_q <= 2'h0;
      for (int i = 0; i < 4; i++) begin
        ob_q[i] <= 8'h00;
        ib_q[i] <= 8'h00;
      end
    end else begin
      if (rd_in1) begin
        full_q[1:0] <= 2'h0;
      end
      if (rd_in2) begin
        full_q[3:2] <= 2'h0;
      end
      if (wr_out1) begin
        ob_q[0] <= i_wdata[7:0];
        ob_q[1] <= i_wdata[15:8];
        empty_q[1:0] <= 2'h0;
      end
      if (wr_out2) begin
        ob_q[2] <= i_wdata[7:0];
        ob_q[3] <= i_wdata[15:8];
        empty_q[3:2] <= 2'h0;
      end
      if (wr_stat) begin
        ovf_q <= i_wdata[`PPM_F_INBUF_OVERFLOW];
        unf_q <= i_wdata[`PPM_F_OUTBUF_UNDERFLOW];
      end
      if (host_wr_ev && !full_q[widx]) begin
        ib_q[widx] <= host_byte;
        full_q[widx] <= 1'b1;
      end
      if (wr_ovf) begin
        ovf_q <= 1'b1;
      end
      if (host_rd_ev) begin
        empty_q[ridx] <= 1'b1;
      end
      if (rd_unf) begin
        unf_q <= 1'b1;
      end
      if (host_wr_ev && ptr_mode) begin
        wptr_q <= wptr_q + 2'h1;
      end
      if (host_rd_ev && ptr_mode) begin
        rptr_q <= rptr_q + 2'h1;
      end
    end
  end

  // Read data stand one cycle after the strobe. Pin data load the byte of the
  // coming phase, so a strobe with no setup phase already drives the new word.
  wire [7:0] mbyte = byte_q ? mdata_q[15:8] : mdata_q[7:0];
  wire [7:0] mnext = (start && wr_data) ? i_wdata[7:0] :
                     (state_q == PPM_GAP) ? mdata_q[15:8] : mbyte;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      rdata_q <= 16'h0000;
      dout_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      rdata_q <= i_rd ? rd_mux : 16'h0000;
      dout_q <= is_master ? mnext : ob_q[ridx];
      irq_q <= irq_cyc || irq_b3;
    end
  end

  // Master strobes follow the selected mode.
  wire m_act = on_q && is_master;
  wire st = m_act && (state_q == PPM_STRB);
  wire mode1 = (f_mode == PPM_MST1);
  assign o_read_strobe = mode1 ? (m_act && in_xfer && dir_q) : (st && dir_q);
  assign o_write_strobe = mode1 ? st : (st && !dir_q);
  assign o_chip_select_one = m_act && in_xfer && addr_q[`PPM_F_CS1];
  assign o_chip_select_two = m_act && in_xfer && addr_q[`PPM_F_CS2];
  assign o_byte_enable = m_act && in_xfer && f_wide && byte_q;
  assign o_address_lines = addr_q;
  assign o_address_lines_oe = m_act ? pen_q : 16'h0000;
  // Stall holds the processor for the whole transfer, busy then says nothing new.
  assign o_stall = busy && (f_irq == PPM_IRQ_STALL);
  assign o_irq = irq_q;
  assign o_pad_ttl = pad_q[0];
  assign o_data_lines = dout_q;
  assign o_data_lines_oe = (m_act && in_xfer && !dir_q) || (slave_on && s_rd);
  assign o_rdata = rdata_q;
endmodule : ppm_port
`default_nettype wire

// ==== dv/ppm_port_sva.sv ====
// Checker for the parallel port: phase lengths, busy, interrupt policy, pins.
// Assumes it is bound to ppm_port and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "ppm_defines.svh"
module ppm_port_sva (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [`PPM_AW-1:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  // Pins and processor side
  input wire logic [15:0] o_address_lines_oe,
  input wire logic o_read_strobe,
  input wire logic o_write_strobe,
  input wire logic o_chip_select_one,
  input wire logic o_irq,
  input wire logic o_stall
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  logic [15:0] md_q;
  logic on_q;
  logic [4:0] cs_n, st_n, ho_n;
  // The combined strobe mode puts direction on the read pin, so only the enable times it.
  wire strb = md_q[8] ? o_write_strobe : (o_read_strobe | o_write_strobe);
  wire [4:0] sw = {1'b0, md_q[5:2]};
  wire [4:0] hold_w = (sw == 5'h00) ? 5'h00 : {3'h0, md_q[1:0]} + 5'h01;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      md_q <= 16'h0000;
      on_q <= 1'b0;
      cs_n <= 5'h00;
      st_n <= 5'h00;
      ho_n <= 5'h00;
    end else begin
      if (i_wr && i_addr == `PPM_A_MODE) md_q <= i_wdata;
      if (i_wr && i_addr == `PPM_A_CTRL) on_q <= i_wdata[15];
      cs_n <= o_chip_select_one ? cs_n + 5'h01 : 5'h00;
      st_n <= strb ? st_n + 5'h01 : 5'h00;
      ho_n <= (o_chip_select_one && !strb) ? ho_n + 5'h01 : 5'h00;
    end
  end
  sequence s_cyc_end;
    $fell(o_chip_select_one) && md_q[9] && !md_q[10];
  endsequence
  setup_len_a:
    assert property ($rose(strb) && sw != 5'h00 |-> cs_n == {3'h0, md_q[7:6]} + 5'h01)
    else $error("setup phase length wrong");
  strobe_len_a:
    assert property ($fell(strb) |-> st_n == sw + 5'h01) else $error("strobe length wrong");
  hold_len_a:
    assert property ($fell(o_chip_select_one) && md_q[9] |-> ho_n == hold_w)
    else $error("hold phase length wrong");
  irq_cycle_a:
    assert property (s_cyc_end |=> o_irq == (md_q[14:13] == 2'h1))
    else $error("end of cycle interrupt wrong");
  quiet_policy_a:
    assert property (md_q[14:13] == 2'h0 |-> !o_irq && !o_stall) else $error("policy zero active");
  stall_busy_a:
    assert property (md_q[14:13] == 2'h2 && strb |-> o_stall) else $error("stall missing");
  busy_flag_a:
    assert property ($past(i_rd) && $past(i_addr) == `PPM_A_MODE && $past(strb) |-> o_rdata[15])
    else $error("busy flag clear during transfer");
  pins_off_a:
    assert property (!on_q |-> o_address_lines_oe == 16'h0000 && !(o_read_strobe || o_write_strobe))
    else $error("port active while off");
endmodule : ppm_port_sva
bind ppm_port ppm_port_sva u_sva (.i_sys_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd,
  .o_rdata, .o_address_lines_oe, .o_read_strobe, .o_write_strobe, .o_chip_select_one,
  .o_irq, .o_stall);
`default_nettype wire

// ==== dv/ppm_mem_model.sv ====
// Byte-wide parallel memory on the master pins, 256 bytes deep.
// Assumes the bench says whether the port uses the combined strobe mode.
`timescale 1ns/1ns
`default_nettype none
module ppm_mem_model (
  // Clock and mode
  input wire logic i_clk,
  input wire logic i_comb,
  // Port pins
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_a,
  input wire logic [7:0] i_d,
  output logic [7:0] o_q
);
  logic [7:0] mem [256];
  logic [7:0] last_q = 8'h00;
  logic [1:0] hold_q = 2'h0;
  logic wr_q = 1'b0;
  int writes = 0;
  wire rd_on = i_comb ? (i_rd & i_wr) : i_rd;
  wire wr_on = i_comb ? (!i_rd & i_wr) : i_wr;
  always @(posedge i_clk) begin
    wr_q <= wr_on;
    if (wr_on) mem[i_a] <= i_d;
    if (wr_on && !wr_q) writes <= writes + 1;
    if (rd_on) last_q <= mem[i_a];
    hold_q <= rd_on ? 2'h2 : hold_q - {1'b0, hold_q != 2'h0};
  end
  // Released lines hold the data two cycles, then show the inverse, so a late sample cannot pass by luck.
  assign o_q = rd_on ? mem[i_a] : ((hold_q != 2'h0) ? last_q : ~last_q);
endmodule : ppm_mem_model
`default_nettype wire

// ==== dv/test_ppm_port.sv ====
// Self-checking bench: registers, master cycles on a memory, slave buffers.
// Assumes the design header on the include path and the memory model compiled.
`timescale 1ns/1ns
`default_nettype none
`include "ppm_defines.svh"
module test_ppm_port;
  logic clk, rst, wr, rd, hs, hr, hw, m1;
  logic [`PPM_AW-1:0] a;
  logic [15:0] wd, rdv, md, v, pa;
  logic [7:0] hd, ad, e;
  logic [7:0] bs [4];
  logic [1:0] ha, p;
  logic [`PPM_AW-1:0] ri [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hF};
  logic [15:0] rv [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h008F, 16'h0000};
  wire [15:0] rdata, al, aoe;
  wire [7:0] dq, pq;
  wire rs, ws, doe, irq, cs2, be, ttl;
  wire [7:0] di = hw ? hd : pq;
  int fails, num_checks, nirq, w0, nbe, ncs, nl;
  ppm_port i_dut (.i_sys_clk(clk), .i_reset(rst), .i_addr(a), .i_wdata(wd), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_data_lines(di), .o_data_lines(dq), .o_data_lines_oe(doe),
    .o_address_lines(al), .o_address_lines_oe(aoe), .o_read_strobe(rs), .o_write_strobe(ws),
    .o_chip_select_one(), .o_chip_select_two(cs2), .o_byte_enable(be), .i_host_read(hr),
    .i_host_write(hw), .i_host_select(hs), .i_host_addr(ha), .o_irq(irq), .o_stall(),
    .o_pad_ttl(ttl));
  ppm_mem_model pm (.i_clk(clk), .i_comb(m1), .i_rd(rs), .i_wr(ws), .i_a(al[7:0]),
    .i_d(dq), .o_q(pq));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic bw(input logic [`PPM_AW-1:0] ix, input logic [15:0] d);
    @(posedge clk);
    a <= ix;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : bw
  task automatic br(input logic [`PPM_AW-1:0] ix);
    @(posedge clk);
    a <= ix;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    rdv = rdata;
  endtask : br
  task automatic idle;
    int n;
    n = 0;
    rdv = 16'h8000;
    while (rdv[15] !== 1'b0 && n < 100) begin
      br(`PPM_A_MODE);
      n++;
    end
    chk({15'h0000, rdv[15]}, 16'h0000, "busy stuck");
  endtask : idle
  // Host pins pass a synchroniser, so each access is held several cycles.
  task automatic hwr(input logic [1:0] ix, input logic [7:0] d);
    @(posedge clk);
    ha <= ix;
    hd <= d;
    hs <= 1'b1;
    hw <= 1'b1;
    repeat (5) @(posedge clk);
    hs <= 1'b0;
    hw <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : hwr
  task automatic hrd(input logic [1:0] ix);
    @(posedge clk);
    ha <= ix;
    hs <= 1'b1;
    hr <= 1'b1;
    repeat (5) @(posedge clk);
    @(negedge clk);
    rdv = {7'h00, doe, dq};
    @(posedge clk);
    hs <= 1'b0;
    hr <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : hrd
  function automatic logic [15:0] nxt(input logic [15:0] x, input logic [1:0] c);
    nxt = x;
    if (c == 2'h1) nxt[10:0] = x[10:0] + 11'h001;
    if (c == 2'h2) nxt[10:0] = x[10:0] - 11'h001;
  endfunction : nxt
  // Cycles of one byte transfer with a select active: setup, strobe and hold.
  function automatic int plen(input logic [15:0] m);
    plen = (m[5:2] == 4'h0) ? 1 : 3 + m[7:6] + m[5:2] + m[1:0];
  endfunction : plen
  task automatic final_report;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (irq === 1'b1) nirq++;
  always @(posedge clk) begin
    if (be === 1'b1) nbe++;
    if (cs2 === 1'b1) ncs++;
  end
  initial begin
    #400000;
    fails++;
    final_report();
  end
  initial begin
    {rst, wr, rd, hs, hr, hw, m1} = 7'h40;
    a = 4'h0;
    wd = 16'h0000;
    hd = 8'h00;
    ha = 2'h0;
    void'($urandom(37));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (ri[k]) begin
      br(ri[k]);
      chk(rdv, rv[k], "reset value");
    end
    chk({15'h0000, ttl}, 16'h0000, "pad reset");
    v = 16'($urandom);
    bw(`PPM_A_ADDR, v);
    br(`PPM_A_ADDR);
    chk(rdv, v, "address rw");
    bw(`PPM_A_MODE, v | 16'h8000);
    br(`PPM_A_MODE);
    chk(rdv, v & 16'h7FFF, "busy writable");
    bw(`PPM_A_STAT, 16'hFFFF);
    br(`PPM_A_STAT);
    chk(rdv, 16'h40CF, "status access");
    bw(`PPM_A_STAT, 16'h0000);
    bw(`PPM_A_PAD, 16'h0001);
    br(`PPM_A_PAD);
    chk(rdv, 16'h0001, "pad word");
    chk({15'h0000, ttl}, 16'h0001, "pad select");
    bw(`PPM_A_PEN, 16'hFFFF);
    bw(`PPM_A_CTRL, 16'h8000);
    for (int i = 0; i < 24; i++) begin
      p = 2'(i % 3);
      md = {1'b0, p, p, p == 2'h0, 1'b1, i[0], 8'($urandom)};
      if (i % 4 == 0) md[5:2] = 4'h0;
      ad = 8'($urandom);
      v = 16'($urandom);
      e = md[10] ? v[15:8] : v[7:0];
      m1 = i[0];
      pa = {i[1], 7'h40, ad};
      nl = md[10] ? 2 * plen(md) : plen(md);
      w0 = pm.writes;
      bw(`PPM_A_ADDR, pa);
      bw(`PPM_A_MODE, md);
      nbe = 0;
      ncs = 0;
      bw(`PPM_A_DATA, v);
      idle();
      chk(16'(pm.writes - w0), md[10] ? 16'h0002 : 16'h0001, "transfers");
      chk({8'h00, pm.mem[ad]}, {8'h00, e}, "byte written");
      chk(16'(nbe), md[10] ? 16'(plen(md)) : 16'h0000, "byte enable");
      chk(16'(ncs), i[1] ? 16'(nl) : 16'h0000, "select two");
      chk(aoe, 16'hFFFF, "pins given");
      br(`PPM_A_ADDR);
      chk(rdv, nxt(pa, p), "address change");
      md[12:11] = 2'h0;
      md[5:2] = 4'h3;
      bw(`PPM_A_ADDR, pa);
      bw(`PPM_A_MODE, md);
      br(`PPM_A_DATA);
      idle();
      br(`PPM_A_DATA);
      chk({8'h00, rdv[7:0]}, {8'h00, e}, "byte read");
      idle();
    end
    bw(`PPM_A_CTRL, 16'h0000);
    w0 = pm.writes;
    bw(`PPM_A_DATA, 16'h00A5);
    repeat (20) @(posedge clk);
    chk(16'(pm.writes - w0), 16'h0000, "write while off");
    chk(aoe, 16'h0000, "pins back");
    bw(`PPM_A_CTRL, 16'h8000);
    bw(`PPM_A_MODE, 16'h7800);
    nirq = 0;
    for (int k = 0; k < 4; k++) begin
      bs[k] = 8'($urandom);
      hwr(2'($urandom), bs[k]);
    end
    br(`PPM_A_STAT);
    chk(rdv, 16'h8F8F, "all full");
    bw(`PPM_A_MODE, 16'h6100);
    hwr(2'h2, 8'h5A);
    br(`PPM_A_STAT);
    chk(rdv, 16'hCF8F, "overflow");
    br(`PPM_A_IN1);
    chk(rdv, {bs[1], bs[0]}, "word one");
    br(`PPM_A_IN2);
    chk(rdv, {bs[3], bs[2]}, "word two");
    br(`PPM_A_STAT);
    chk(rdv, 16'h408F, "read clears full");
    v = 16'($urandom);
    bw(`PPM_A_OUT1, v);
    br(`PPM_A_STAT);
    chk(rdv, 16'h400C, "out written");
    hrd(2'h1);
    chk(rdv, {7'h00, 1'b1, v[15:8]}, "host read byte");
    hrd(2'h2);
    hrd(2'h0);
    br(`PPM_A_STAT);
    chk(rdv, 16'h40CF, "sent and underflow");
    chk(16'(nirq), 16'h0001, "buffer three irq");
    final_report();
  end
endmodule : test_ppm_port
`default_nettype wire
